// >>> common/ddr_cell_pkg.sv
// Shared constants and carrier types for the double-rate pin cell.
// Assumes a 25 MHz system clock that oversamples the I/O clock and strobe.
package ddr_cell_pkg;

  // Mode selection
  typedef enum logic [1:0] {
    MODE_IDLE  = 2'b00,
    MODE_INPUT = 2'b01,
    MODE_OUTPUT = 2'b10,
    MODE_BIDIR = 2'b11
  } ddr_mode_t;

  // Per-signal polarity inversion flags at the pin cell
  typedef struct packed {
    logic pad_in;
    logic out_hi;
    logic out_lo;
    logic oe;
    logic ce_out;
    logic sclr;
  } inv_sel_t;

  // Documented group widths and rates
  localparam int DQ_WIDTH_X8 = 8;
  localparam int DQ_WIDTH_X16 = 16;
  localparam int DQ_WIDTH_X32 = 32;
  localparam int DDR_MAX_CLK_MHZ = 200;
  localparam int DDR_PIN_MBPS = 2 * DDR_MAX_CLK_MHZ;
  localparam int SYS_CLK_MHZ = 25;
  localparam int CELL_REG_COUNT = 6;

  // Buffer shape
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 2;

  // Reset and preset values
  localparam logic RST_VAL = 1'b0;
  localparam logic PRESET_VAL = 1'b1;

endpackage

// >>> hdl/ddr_pair_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
module ddr_pair_fifo
  import ddr_cell_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic do_wr, do_rd;

  // Honest full and empty from the fill count
  assign o_wr_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_rd_valid = (count_reg != '0);
  assign do_wr = i_wr_valid && o_wr_ready;
  assign do_rd = o_rd_valid && i_rd_ready;
  assign o_rd_data = mem_reg[rd_ptr_reg];

  // Pointer and count update
  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (do_wr)
    begin
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (do_rd)
    begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (do_wr && !do_rd)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (do_rd && !do_wr)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk)
  begin
    if (do_wr)
    begin
      mem_reg[wr_ptr_reg] <= i_wr_data;
    end
  end

endmodule

// >>> hdl/ddr_io_register_cell.sv
// Double-rate pin cell group: input capture, output launch, output enable.
// Assumes the I/O clock, strobe and pads are asynchronous to I_CLK_SYS,
// which runs fast enough to see every phase of them.
module ddr_io_register_cell
  import ddr_cell_pkg::*;
#(
  parameter int DQ_WIDTH = DQ_WIDTH_X8,
  parameter int BUF_DEPTH = FIFO_DEPTH
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_IO_CLK,
  input wire logic I_DQS,
  input wire logic [1:0] I_MODE,
  input wire logic I_SIDE_BANK,
  input wire logic I_OE_ACT_LOW,
  input wire logic I_PRESET_SEL,
  input wire inv_sel_t I_INV,
  input wire logic I_SCLR,
  input wire logic I_CE_OUT,
  input wire logic I_OE,
  input wire logic [DQ_WIDTH-1:0] I_OUT_HI,
  input wire logic [DQ_WIDTH-1:0] I_OUT_LO,
  input wire logic [DQ_WIDTH-1:0] I_PAD_IN,
  output logic [DQ_WIDTH-1:0] O_PAD_OUT,
  output logic [DQ_WIDTH-1:0] O_PAD_OE,
  output logic O_RD_VALID,
  input wire logic I_RD_READY,
  output logic [DQ_WIDTH-1:0] O_RD_HI,
  output logic [DQ_WIDTH-1:0] O_RD_LO,
  output logic O_OVERRUN
);

  // Group width must be one of the strobe-group sizes
  localparam bit WIDTH_OK = (DQ_WIDTH == DQ_WIDTH_X8) ||
                            (DQ_WIDTH == DQ_WIDTH_X16) ||
                            (DQ_WIDTH == DQ_WIDTH_X32);
  localparam int PW = 2 * DQ_WIDTH;

  ddr_mode_t mode;
  logic in_en, out_en, bidir;

  // Synchroniser chains for pins and the two clocks
  logic [DQ_WIDTH-1:0] pad_s1_reg, pad_s2_reg;
  logic ioclk_s1_reg, ioclk_s2_reg, ioclk_d_reg;
  logic dqs_s1_reg, dqs_s2_reg, dqs_d_reg;

  logic io_rise, io_fall, io_high;
  logic cap_rise, cap_fall, cap_high;
  logic [DQ_WIDTH-1:0] pad_val;
  logic sclr_eff, ce_eff, oe_in;
  logic [DQ_WIDTH-1:0] hi_in, lo_in;
  logic [DQ_WIDTH-1:0] clr_val;

  // The six cell registers plus the input latch
  logic [DQ_WIDTH-1:0] in_rise_reg, in_rise_next;
  logic [DQ_WIDTH-1:0] in_fall_reg, in_fall_next;
  logic [DQ_WIDTH-1:0] latch_reg, latch_next;
  logic [DQ_WIDTH-1:0] out_hi_reg, out_hi_next;
  logic [DQ_WIDTH-1:0] out_lo_reg, out_lo_next;
  logic oe_rise_reg, oe_rise_next;
  logic oe_fall_reg, oe_fall_next;
  logic push_reg, push_next;
  logic overrun_reg, overrun_next;
  logic [DQ_WIDTH-1:0] pad_out_reg, pad_out_next;
  logic pad_oe_reg, pad_oe_next;

  logic fifo_ready;
  logic [PW-1:0] fifo_rd_data;
  logic oe_sel, oe_act;

  // Mode decode; bidirectional mode enables both paths and selects the falling-edge enable register
  assign mode = ddr_mode_t'(I_MODE);
  assign bidir = (mode == MODE_BIDIR);
  assign in_en = (mode == MODE_INPUT) || bidir;
  assign out_en = (mode == MODE_OUTPUT) || bidir;

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      pad_s1_reg <= '0;
      pad_s2_reg <= '0;
      ioclk_s1_reg <= 1'b0;
      ioclk_s2_reg <= 1'b0;
      ioclk_d_reg <= 1'b0;
      dqs_s1_reg <= 1'b0;
      dqs_s2_reg <= 1'b0;
      dqs_d_reg <= 1'b0;
    end
    else
    begin
      pad_s1_reg <= I_PAD_IN;
      pad_s2_reg <= pad_s1_reg;
      ioclk_s1_reg <= I_IO_CLK;
      ioclk_s2_reg <= ioclk_s1_reg;
      ioclk_d_reg <= ioclk_s2_reg;
      dqs_s1_reg <= I_DQS;
      dqs_s2_reg <= dqs_s1_reg;
      dqs_d_reg <= dqs_s2_reg;
    end
  end

  // Edge detection on the synchronised clocks
  assign io_rise = ioclk_s2_reg && !ioclk_d_reg;
  assign io_fall = !ioclk_s2_reg && ioclk_d_reg;
  assign io_high = ioclk_s2_reg;

  // Side banks have no strobe path: the strobe is ignored there
  always_comb
  begin
    if (I_SIDE_BANK)
    begin
      cap_rise = io_rise;
      cap_fall = io_fall;
      cap_high = io_high;
    end
    else
    begin
      cap_rise = dqs_s2_reg && !dqs_d_reg;
      cap_fall = !dqs_s2_reg && dqs_d_reg;
      cap_high = dqs_s2_reg;
    end
  end

  // Optional inversion of the pad input, both output data inputs, enable, clock enable and clear
  assign pad_val = pad_s2_reg ^ {DQ_WIDTH{I_INV.pad_in}};
  assign hi_in = I_OUT_HI ^ {DQ_WIDTH{I_INV.out_hi}};
  assign lo_in = I_OUT_LO ^ {DQ_WIDTH{I_INV.out_lo}};
  assign oe_in = I_OE ^ I_INV.oe;
  assign ce_eff = I_CE_OUT ^ I_INV.ce_out;
  assign sclr_eff = I_SCLR ^ I_INV.sclr;

  // One clear-or-preset value shared by the six cell registers and the input latch
  assign clr_val = {DQ_WIDTH{I_PRESET_SEL ? PRESET_VAL : RST_VAL}};

  // Input path: rising and falling capture plus the clock-high latch
  always_comb
  begin
    in_rise_next = in_rise_reg;
    in_fall_next = in_fall_reg;
    latch_next = latch_reg;
    push_next = 1'b0;
    if (sclr_eff)
    begin
      in_rise_next = clr_val;
      in_fall_next = clr_val;
      latch_next = clr_val;
    end
    else if (in_en)
    begin
      if (cap_rise)
      begin
        in_rise_next = pad_val;
      end
      if (cap_high)
      begin
        latch_next = in_rise_reg;
      end
      if (cap_fall)
      begin
        in_fall_next = pad_val;
        push_next = 1'b1;
      end
    end
  end

  // Output path: data and rising-edge enable load on rising edges when enabled; falling-edge enable follows on falling edges
  always_comb
  begin
    out_hi_next = out_hi_reg;
    out_lo_next = out_lo_reg;
    oe_rise_next = oe_rise_reg;
    oe_fall_next = oe_fall_reg;
    if (sclr_eff)
    begin
      out_hi_next = clr_val;
      out_lo_next = clr_val;
      oe_rise_next = clr_val[0];
      oe_fall_next = clr_val[0];
    end
    else
    begin
      if (io_rise && ce_eff)
      begin
        out_hi_next = hi_in;
        out_lo_next = lo_in;
        oe_rise_next = oe_in;
      end
      if (io_fall)
      begin
        oe_fall_next = oe_rise_reg;
      end
    end
  end

  // Bidirectional drive waits for the falling-edge enable register
  assign oe_sel = bidir ? oe_fall_reg : oe_rise_reg;
  // Enable polarity default high, optionally low
  assign oe_act = out_en && (I_OE_ACT_LOW ? !oe_sel : oe_sel);

  // Pin mux: first bit while the clock is high, second while low
  always_comb
  begin
    pad_out_next = io_high ? out_hi_reg : out_lo_reg;
    pad_oe_next = oe_act;
    if (!oe_act)
    begin
      pad_out_next = '0;
    end
  end

  // Overrun: the pin cannot be stalled, so a full buffer drops a pair
  always_comb
  begin
    overrun_next = overrun_reg;
    if (push_reg && !fifo_ready)
    begin
      overrun_next = 1'b1;
    end
    else if (sclr_eff)
    begin
      overrun_next = 1'b0;
    end
  end

  // Register stage for all cell state
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      in_rise_reg <= '0;
      in_fall_reg <= '0;
      latch_reg <= '0;
      out_hi_reg <= '0;
      out_lo_reg <= '0;
      oe_rise_reg <= 1'b0;
      oe_fall_reg <= 1'b0;
      push_reg <= 1'b0;
      overrun_reg <= 1'b0;
      pad_out_reg <= '0;
      pad_oe_reg <= 1'b0;
    end
    else
    begin
      in_rise_reg <= in_rise_next;
      in_fall_reg <= in_fall_next;
      latch_reg <= latch_next;
      out_hi_reg <= out_hi_next;
      out_lo_reg <= out_lo_next;
      oe_rise_reg <= oe_rise_next;
      oe_fall_reg <= oe_fall_next;
      push_reg <= push_next;
      overrun_reg <= overrun_next;
      pad_out_reg <= pad_out_next;
      pad_oe_reg <= pad_oe_next;
    end
  end

  // Every pin of the group shares the one enable and clock mux
  assign O_PAD_OUT = pad_out_reg;
  assign O_PAD_OE = {DQ_WIDTH{pad_oe_reg}};
  assign O_OVERRUN = overrun_reg;

  // Pair buffer: latched rising bit and falling bit, one entry per period
  ddr_pair_fifo #(
    .WIDTH(PW),
    .DEPTH(BUF_DEPTH)
  ) u_pair_fifo (
    .clk(I_CLK_SYS),
    .rst_b(I_RST_B),
    .i_wr_valid(push_reg && WIDTH_OK),
    .o_wr_ready(fifo_ready),
    .i_wr_data({latch_reg, in_fall_reg}),
    .o_rd_valid(O_RD_VALID),
    .i_rd_ready(I_RD_READY),
    .o_rd_data(fifo_rd_data)
  );

  // Fabric side sees both bits of a period together
  assign O_RD_HI = fifo_rd_data[PW-1:DQ_WIDTH];
  assign O_RD_LO = fifo_rd_data[DQ_WIDTH-1:0];

endmodule

// >>> bench/ddr_cell_assertions.sv
// Port checker for the double-rate pin cell.
// Assumes it is bound to the top module; inputs follow its port names.
module ddr_cell_assertions
  import ddr_cell_pkg::*;
#(
  parameter int DQ_WIDTH = 8
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_IO_CLK,
  input wire logic [1:0] I_MODE,
  input wire logic I_OE_ACT_LOW,
  input wire inv_sel_t I_INV,
  input wire logic I_SCLR,
  input wire logic I_OE,
  input wire logic I_RD_READY,
  input wire logic [DQ_WIDTH-1:0] O_PAD_OUT,
  input wire logic [DQ_WIDTH-1:0] O_PAD_OE,
  input wire logic O_RD_VALID,
  input wire logic [DQ_WIDTH-1:0] O_RD_HI,
  input wire logic [DQ_WIDTH-1:0] O_RD_LO,
  input wire logic O_OVERRUN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);
  logic eff_oe;
  logic clr;
  // Effective controls after inversion and polarity choice
  assign eff_oe = I_OE ^ I_OE_ACT_LOW ^ I_INV.oe;
  assign clr = I_SCLR ^ I_INV.sclr;

  a_idle_no_drive: assert property ((!I_MODE[1])[*3] |-> O_PAD_OE == '0)
    else $error("pad driven outside output modes");
  a_hiz_zero_data: assert property (O_PAD_OE == '0 |-> O_PAD_OUT == '0)
    else $error("pad data not zero while released");
  a_oe_all_bits: assert property (O_PAD_OE == '0 || O_PAD_OE == '1)
    else $error("pad enables split across bits");
  a_oe_polarity: assert property ($rose(O_PAD_OE[0]) |-> eff_oe)
    else $error("pad enabled with enable inactive");
  a_bidir_oe_delay: assert property (
    $rose(O_PAD_OE[0]) && I_MODE == MODE_BIDIR && $past(I_MODE) == MODE_BIDIR
    |-> !$past(I_IO_CLK, 3))
    else $error("bidirectional enable before falling edge");
  a_overrun_sticky: assert property (O_OVERRUN && !clr |=> O_OVERRUN)
    else $error("overrun flag lost without clear");
  a_pair_holds: assert property (
    O_RD_VALID && !I_RD_READY && !clr
    |=> O_RD_VALID && $stable(O_RD_HI) && $stable(O_RD_LO))
    else $error("read pair changed while stalled");
  a_no_capture: assert property (
    (!I_MODE[0] && !O_RD_VALID)[*8] |=> !O_RD_VALID)
    else $error("pair captured in a non-input mode");
endmodule

// >>> bench/ddr_mem_model.sv
// Memory-side model: returns a counting read burst on the pins.
// Assumes mclk is the memory clock and rd_en frames a burst.
module ddr_mem_model
(
  input wire logic mclk,
  input wire logic rd_en,
  output logic dqs,
  output logic [7:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] n;
  initial
  begin
    dqs = 1'b0;
    dq = 8'h00;
    n = 8'h00;
  end
  // Hi beat on rise, lo beat on fall; idle lines toggle, never hold
  always @(mclk)
  begin
    if (!rd_en)
    begin
      dq <= ~dq;
      n <= 8'h00;
    end
    else if (mclk)
      dq <= 8'h10 + n;
    else
    begin
      dq <= 8'h80 + n;
      n <= n + 8'h01;
    end
    // Strobe a quarter period late, mid-beat; quiet outside bursts
    dqs <= #80 mclk & rd_en;
  end
endmodule

// >>> bench/tb_ddr_io_register_cell.sv
// Self-checking bench for the double-rate pin cell.
// Assumes ddr_mem_model drives the pins and strobe.
module tb_ddr_io_register_cell;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr_cell_pkg::*;
  logic I_CLK_SYS, I_RST_B, I_IO_CLK, I_SIDE_BANK, I_OE_ACT_LOW;
  logic I_PRESET_SEL, I_SCLR, I_CE_OUT, I_OE, I_RD_READY, mclk, rd_en;
  logic [1:0] I_MODE;
  inv_sel_t I_INV;
  logic [7:0] I_OUT_HI, I_OUT_LO, O_PAD_OUT, O_PAD_OE, O_RD_HI, O_RD_LO;
  logic [7:0] dq, got_hi, got_lo;
  logic O_RD_VALID, O_OVERRUN, dqs;
  int miscompares, comparisons, cycles;

  ddr_io_register_cell dut (.I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B),
    .I_IO_CLK(I_IO_CLK), .I_DQS(dqs & !I_SIDE_BANK), .I_MODE(I_MODE),
    .I_SIDE_BANK(I_SIDE_BANK), .I_OE_ACT_LOW(I_OE_ACT_LOW),
    .I_PRESET_SEL(I_PRESET_SEL), .I_INV(I_INV), .I_SCLR(I_SCLR),
    .I_CE_OUT(I_CE_OUT), .I_OE(I_OE), .I_OUT_HI(I_OUT_HI),
    .I_OUT_LO(I_OUT_LO), .I_PAD_IN(dq), .O_PAD_OUT(O_PAD_OUT),
    .O_PAD_OE(O_PAD_OE), .O_RD_VALID(O_RD_VALID), .I_RD_READY(I_RD_READY),
    .O_RD_HI(O_RD_HI), .O_RD_LO(O_RD_LO), .O_OVERRUN(O_OVERRUN));
  ddr_mem_model mem (.mclk(mclk), .rd_en(rd_en), .dqs(dqs), .dq(dq));

  // Clocks: I/O clock lags the memory clock by a quarter period
  initial
  begin
    I_CLK_SYS = 1'b0;
    forever #20 I_CLK_SYS = ~I_CLK_SYS;
  end
  initial
  begin
    mclk = 1'b0;
    forever #160 mclk = ~mclk;
  end
  always @(mclk) I_IO_CLK <= #80 mclk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK_SYS);
  endtask
  // Wait bounded for a pair, take it, pulse ready
  task automatic pop();
    int k;
    k = 0;
    while (O_RD_VALID !== 1'b1 && k < 80)
    begin
      tick(1);
      k++;
    end
    check(O_RD_VALID, 16'h1);
    got_hi = O_RD_HI;
    got_lo = O_RD_LO;
    I_RD_READY <= 1'b1;
    tick(1);
    I_RD_READY <= 1'b0;
    tick(1);
  endtask
  task automatic rd_pair(input logic [7:0] hi, input logic [7:0] lo);
    pop();
    check(got_hi, hi);
    check(got_lo, lo);
  endtask
  // Pin shows hi late in the high half, lo late in the low half
  task automatic out_phase(input logic [7:0] hi, input logic [7:0] lo);
    @(posedge I_IO_CLK);
    tick(6);
    check(O_PAD_OUT, hi);
    tick(4);
    check(O_PAD_OUT, lo);
  endtask

  // Hang guard
  always @(posedge I_CLK_SYS)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  initial
  begin
    {I_RST_B, I_SIDE_BANK, I_OE_ACT_LOW, I_PRESET_SEL, I_SCLR} = 5'h00;
    {I_OE, I_RD_READY, rd_en, I_CE_OUT} = 4'h1;
    {I_MODE, I_INV, I_OUT_HI, I_OUT_LO} = 24'h000000;
    {miscompares, comparisons, cycles} = 96'h0;
    tick(20);
    I_RST_B <= 1'b1;
    tick(2);
    check(O_PAD_OE, 8'h00);
    I_MODE <= MODE_OUTPUT;
    I_OE <= 1'b1;
    {I_OUT_HI, I_OUT_LO} <= 16'ha53c;
    tick(16);
    out_phase(8'ha5, 8'h3c);
    check(O_PAD_OE, 8'hff);
    I_CE_OUT <= 1'b0;
    {I_OUT_HI, I_OUT_LO} <= 16'h1122;
    tick(16);
    out_phase(8'ha5, 8'h3c);
    I_CE_OUT <= 1'b1;
    tick(16);
    out_phase(8'h11, 8'h22);
    I_INV.out_hi <= 1'b1;
    tick(16);
    out_phase(8'hee, 8'h22);
    I_INV <= '0;
    I_OE_ACT_LOW <= 1'b1;
    tick(16);
    check({O_PAD_OE, O_PAD_OUT}, 16'h0000);
    I_OE <= 1'b0;
    tick(16);
    check(O_PAD_OE, 8'hff);
    {I_OE_ACT_LOW, I_OE, I_MODE} <= {2'b00, MODE_IDLE};
    tick(16);
    check(O_PAD_OE, 8'h00);
    // Bidirectional: enable off first, so both enable registers start low
    I_MODE <= MODE_BIDIR;
    tick(16);
    check(O_PAD_OE, 8'h00);
    @(negedge I_IO_CLK);
    tick(1);
    I_OE <= 1'b1;
    @(posedge I_IO_CLK);
    tick(6);
    check(O_PAD_OE, 8'h00);
    tick(4);
    check(O_PAD_OE, 8'hff);
    // Capture: overfill the buffer while the fabric stalls
    I_MODE <= MODE_INPUT;
    tick(8);
    check(O_PAD_OE, 8'h00);
    @(negedge mclk);
    #1 rd_en = 1'b1;
    repeat (18) @(posedge mclk);
    @(negedge mclk);
    #1 rd_en = 1'b0;
    tick(8);
    check(O_OVERRUN, 16'h1);
    for (int i = 0; i < 16; i++)
      rd_pair(8'h10 + 8'(i), 8'h80 + 8'(i));
    tick(4);
    check(O_RD_VALID, 16'h0);
    I_SCLR <= 1'b1;
    tick(2);
    I_SCLR <= 1'b0;
    tick(2);
    check(O_OVERRUN, 16'h0);
    // Side bank: strobe masked; capture opens just after a memory rise,
    // so the idle toggling on the pins never forms a pair
    {I_SIDE_BANK, I_MODE} <= {1'b1, MODE_IDLE};
    @(negedge mclk);
    #1 rd_en = 1'b1;
    @(posedge mclk);
    tick(1);
    I_MODE <= MODE_INPUT;
    for (int i = 0; i < 4; i++)
      rd_pair(8'h10 + 8'(i), 8'h80 + 8'(i));
    I_MODE <= MODE_IDLE;
    rd_en = 1'b0;
    tick(12);
    while (O_RD_VALID === 1'b1)
      pop();
    check(O_RD_VALID, 16'h0);
    // Preset: sync reset loads ones, kept by an inverted clock enable
    I_MODE <= MODE_OUTPUT;
    {I_PRESET_SEL, I_INV.ce_out, I_SCLR} <= 3'b111;
    tick(2);
    I_SCLR <= 1'b0;
    tick(12);
    check({O_PAD_OE, O_PAD_OUT}, 16'hffff);
    conclude();
  end
endmodule

bind ddr_io_register_cell ddr_cell_assertions #(.DQ_WIDTH(DQ_WIDTH)) chk (.*);
